// file: frwg_pkg.sv
// Package with register map, codes and timing constants of the waveform unit.
package frwg_pkg;
	localparam logic [7:0] QUEUE_WINDOW_OFFS = 8'h00;
	localparam logic [7:0] QUEUE_CLEAR_OFFS = 8'h04;
	localparam logic [7:0] PATH_SELECT_OFFS = 8'h08;
	localparam logic [7:0] DIRECT_WORD_OFFS = 8'h0c;
	localparam logic [7:0] QUEUE_CONTROL_OFFS = 8'h10;
	localparam logic [7:0] REPEAT_COUNT_OFFS = 8'h14;
	localparam logic [7:0] START_STOP_OFFS = 8'h18;
	localparam logic [7:0] IRQ_SOURCE_OFFS = 8'h1c;
	localparam logic [7:0] IRQ_MASTER_OFFS = 8'h20;
	localparam logic [7:0] STATUS_OFFS = 8'h24;
	localparam logic [31:0] DIRECT_PATH_CODE = 32'h0000_0001;
	localparam logic [31:0] QUEUE_PATH_CODE = 32'h0000_0002;
	localparam logic [31:0] COMBINED_CODE = 32'h0000_0001;
	localparam logic [31:0] RUN_CODE = 32'h0000_0001;
	localparam logic [31:0] HALT_CODE = 32'h0000_0000;
	localparam logic [31:0] REPLAY_IRQ_CODE = 32'h0000_0001;
	localparam logic [31:0] PLAYBACK_DONE_IRQ_CODE = 32'h0000_0002;
	localparam logic [31:0] MASTER_ENABLE_CODE = 32'h0000_0001;
	localparam int QUEUE_DEPTH = 16384;
	localparam logic [12:0] REPEAT_MAX = 13'h1000;
	localparam int CLK_PERIOD_NS = 4;
	localparam int QUEUE_WORD_NS = 200;
	localparam int DIRECT_WORD_NS = 320;
	localparam int QUEUE_WORD_CYCLES = QUEUE_WORD_NS / CLK_PERIOD_NS;
	localparam int DIRECT_WORD_CYCLES = DIRECT_WORD_NS / CLK_PERIOD_NS;
	typedef struct packed {
		logic [15:0] high;
		logic [15:0] low;
	} frwg_word_t;
	typedef enum logic [2:0] {
		FRWG_IDLE = 3'b001,
		FRWG_PLAY = 3'b010,
		FRWG_DONE = 3'b100
	} frwg_state_t;
endpackage

// file: frwg_generator.sv
// Waveform generator: queue replay with repeat count plus direct output.
//
// How it works
// - any write to clear register empties queue
// - window writes append 32-bit words in sequence
// - two 16-bit halves, separate or locked
// - direct and queue paths share one port
// - path select code picks direct or queue
// - direct words appear at once, no repetition
// - combined code locks both halves in step
// - repeat count clipped to 4096
// - run code replays whole queue count times; a zero count plays it once
// - replay event after each pass but last
// - done event after final pass output
// - zero clears source and disarms; code selects event source
// - event armed only after master enable
// - armed event toggles the event line
// - queue is 32 bits by 16384 entries
// - queue word every 200ns, direct word on each write
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
module frwg_generator #(
	parameter int DEPTH = frwg_pkg::QUEUE_DEPTH,
	parameter int AW = $clog2(DEPTH)
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output frwg_pkg::frwg_word_t portWord,
	output logic eventLine
);
	import frwg_pkg::*;

	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	logic [31:0] queueMem [DEPTH];
	logic [AW:0] fillReg, fillNext;
	logic [AW:0] rdPtrReg, rdPtrNext;
	logic pathQueueReg, pathQueueNext;
	logic combinedReg, combinedNext;
	logic [12:0] repHighReg, repHighNext, repLowReg, repLowNext;
	logic [12:0] passReg, passNext;
	logic [7:0] tickReg, tickNext;
	frwg_state_t stateReg, stateNext;
	frwg_word_t portReg, portNext;
	logic [1:0] srcReg, srcNext;
	logic masterReg, masterNext;
	logic eventReg, eventNext;
	logic [31:0] prdataReg, prdataNext;
	logic readyReg, readyNext;
	logic errReg, errNext;
	logic access, wr, passEnd, lastPass, replayEv, doneEv, fire;
	logic [12:0] repIn;

	assign access = psel && penable && !readyReg;
	assign wr = access && pwrite;
	// Counts above the hardware limit are clipped on load.
	assign repIn = (pwdata > 32'(REPEAT_MAX)) ? REPEAT_MAX
		: pwdata[12:0];

	// Storage write port; entries persist across passes.
	always_ff @(posedge core_clk) begin
		if (wr && paddr == QUEUE_WINDOW_OFFS && fillReg < (AW+1)'(DEPTH)) begin
			queueMem[fillReg[AW-1:0]] <= pwdata;
		end
	end

	assign passEnd = stateReg == FRWG_PLAY && tickReg == 8'h00
		&& rdPtrReg == fillReg;
	assign lastPass = passReg <= 13'h0001;
	assign replayEv = passEnd && !lastPass;
	assign doneEv = passEnd && lastPass;
	assign fire = masterReg && ((srcReg[0] && replayEv)
		|| (srcReg[1] && doneEv));

	always_comb begin
		fillNext = fillReg;
		rdPtrNext = rdPtrReg;
		pathQueueNext = pathQueueReg;
		combinedNext = combinedReg;
		repHighNext = repHighReg;
		repLowNext = repLowReg;
		passNext = passReg;
		tickNext = tickReg;
		stateNext = stateReg;
		portNext = portReg;
		srcNext = srcReg;
		masterNext = masterReg;
		eventNext = eventReg ^ fire;
		prdataNext = prdataReg;
		readyNext = access;
		errNext = 1'b0;
		if (tickReg != 8'h00) begin
			tickNext = tickReg - 8'h01;
		end
		unique case (stateReg)
			FRWG_IDLE: ;
			FRWG_PLAY: begin
				if (tickReg == 8'h00) begin
					if (rdPtrReg == fillReg) begin
						if (lastPass) begin
							stateNext = FRWG_DONE;
						end else begin
							passNext = passReg - 13'h0001;
							rdPtrNext = '0;
						end
					end else begin
						if (pathQueueReg) begin
							// Halves move together when combined, else the
							// low half alone follows the queue.
							portNext.low = queueMem[rdPtrReg[AW-1:0]][15:0];
							if (combinedReg) begin
								portNext.high =
									queueMem[rdPtrReg[AW-1:0]][31:16];
							end
						end
						rdPtrNext = rdPtrReg + (AW+1)'(1);
						tickNext = 8'(QUEUE_WORD_CYCLES - 1);
					end
				end
			end
			FRWG_DONE: ;
		endcase
		if (access) begin
			prdataNext = 32'h0000_0000;
			if (pwrite) begin
				unique case (paddr)
					QUEUE_WINDOW_OFFS: if (fillReg < (AW+1)'(DEPTH)) begin
						fillNext = fillReg + (AW+1)'(1);
					end
					QUEUE_CLEAR_OFFS: begin
						fillNext = '0;
						rdPtrNext = '0;
					end
					PATH_SELECT_OFFS: begin
						if (pwdata == DIRECT_PATH_CODE) begin
							pathQueueNext = 1'b0;
						end else if (pwdata == QUEUE_PATH_CODE) begin
							pathQueueNext = 1'b1;
						end
					end
					DIRECT_WORD_OFFS: if (!pathQueueReg) begin
						portNext = pwdata;
					end
					QUEUE_CONTROL_OFFS: begin
						combinedNext = pwdata == COMBINED_CODE;
					end
					REPEAT_COUNT_OFFS: begin
						repLowNext = repIn;
						repHighNext = repIn;
					end
					START_STOP_OFFS: begin
						if (pwdata == RUN_CODE) begin
							stateNext = FRWG_PLAY;
							rdPtrNext = '0;
							passNext = repLowReg;
							tickNext = 8'h00;
						end else if (pwdata == HALT_CODE) begin
							stateNext = FRWG_IDLE;
						end
					end
					IRQ_SOURCE_OFFS: begin
						// Zero also disarms, so stale events cannot toggle.
						srcNext = pwdata[1:0];
						if (pwdata == 32'h0000_0000) begin
							masterNext = 1'b0;
						end
					end
					IRQ_MASTER_OFFS: begin
						masterNext = pwdata == MASTER_ENABLE_CODE;
					end
					default: errNext = paddr != STATUS_OFFS;
				endcase
			end else begin
				unique case (paddr)
					PATH_SELECT_OFFS: prdataNext = pathQueueReg
						? QUEUE_PATH_CODE : DIRECT_PATH_CODE;
					DIRECT_WORD_OFFS: prdataNext = portReg;
					QUEUE_CONTROL_OFFS: prdataNext = {31'h0, combinedReg};
					REPEAT_COUNT_OFFS: prdataNext = {3'h0, repHighReg,
						3'h0, repLowReg};
					IRQ_SOURCE_OFFS: prdataNext = {30'h0, srcReg};
					IRQ_MASTER_OFFS: prdataNext = {31'h0, masterReg};
					// A completely full queue of 16384 entries reads back as zero fill.
					STATUS_OFFS: prdataNext = {3'h0, passReg,
						1'(stateReg == FRWG_DONE),
						1'(stateReg == FRWG_PLAY), 14'(fillReg)};
					default: errNext = 1'b1;
				endcase
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			fillReg <= '0;
			rdPtrReg <= '0;
			pathQueueReg <= 1'b0;
			combinedReg <= 1'b0;
			repHighReg <= '0;
			repLowReg <= '0;
			passReg <= '0;
			tickReg <= '0;
			stateReg <= FRWG_IDLE;
			portReg <= '0;
			srcReg <= '0;
			masterReg <= 1'b0;
			eventReg <= 1'b0;
			prdataReg <= '0;
			readyReg <= 1'b0;
			errReg <= 1'b0;
		end else begin
			fillReg <= fillNext;
			rdPtrReg <= rdPtrNext;
			pathQueueReg <= pathQueueNext;
			combinedReg <= combinedNext;
			repHighReg <= repHighNext;
			repLowReg <= repLowNext;
			passReg <= passNext;
			tickReg <= tickNext;
			stateReg <= stateNext;
			portReg <= portNext;
			srcReg <= srcNext;
			masterReg <= masterNext;
			eventReg <= eventNext;
			prdataReg <= prdataNext;
			readyReg <= readyNext;
			errReg <= errNext;
		end
	end

	assign prdata = prdataReg;
	assign pready = readyReg;
	assign pslverr = errReg;
	assign portWord = portReg;
	assign eventLine = eventReg;

	sequence clearWrite;
		wr && paddr == QUEUE_CLEAR_OFFS;
	endsequence

	queue_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		clearWrite |=> fillReg == '0)
		else $error("Clear write did not empty the queue.");
	queue_fill_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		wr && paddr == QUEUE_WINDOW_OFFS && fillReg < (AW+1)'(DEPTH)
		|=> fillReg == $past(fillReg) + (AW+1)'(1))
		else $error("Window write did not add one entry.");
	direct_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		wr && paddr == DIRECT_WORD_OFFS && !pathQueueReg
		|=> portWord == $past(pwdata))
		else $error("Direct word did not reach the port.");
	repeat_clip_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		repLowReg <= REPEAT_MAX && repHighReg <= REPEAT_MAX)
		else $error("Repeat count above limit.");
	run_start_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		wr && paddr == START_STOP_OFFS && pwdata == RUN_CODE
		|=> stateReg == FRWG_PLAY && rdPtrReg == '0)
		else $error("Run code did not start playback.");
	event_arm_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		!masterReg |=> eventLine == $past(eventLine))
		else $error("Event line moved while disarmed.");
	event_toggle_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		fire |=> eventLine != $past(eventLine))
		else $error("Armed event did not toggle the line.");
	word_pace_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		stateReg == FRWG_PLAY && $changed(rdPtrReg) && rdPtrReg != '0
		|=> !$changed(rdPtrReg) [*8])
		else $error("Queue words issued faster than pace.");
	port_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		stateReg != FRWG_PLAY && !wr |=> $stable(portWord))
		else $error("Port changed with no new word.");

	// Steps of a bus access and of the end of a pass.
	sequence busAccess;
		access;
	endsequence

	sequence busAnswer;
		pready ##1 !pready;
	endsequence

	sequence finalPassEnd;
		passEnd && lastPass;
	endsequence

	sequence earlyPassEnd;
		passEnd && !lastPass;
	endsequence

	ready_pulse_a: assert property (busAccess |=> busAnswer)
		else $error("Bus access not answered by a one-cycle ready.");

	error_with_ready_a: assert property (pslverr |-> pready)
		else $error("Slave error shown without ready.");

	path_queue_a: assert property (
		wr && paddr == PATH_SELECT_OFFS && pwdata == QUEUE_PATH_CODE
		|=> pathQueueReg)
		else $error("Queue path code did not select the queue.");

	direct_refuse_a: assert property (
		wr && paddr == DIRECT_WORD_OFFS && pathQueueReg
		&& stateReg != FRWG_PLAY |=> $stable(portWord))
		else $error("Direct word reached the port on queue path.");

	split_halves_a: assert property (
		stateReg == FRWG_PLAY && tickReg == 8'h00 && rdPtrReg != fillReg
		&& !combinedReg |=> $stable(portWord.high))
		else $error("High half moved while halves were separate.");

	replay_restart_a: assert property (
		earlyPassEnd |=> rdPtrReg == '0
		&& passReg == $past(passReg) - 13'h0001)
		else $error("Pass end did not restart from the first entry.");

	done_state_a: assert property (finalPassEnd |=> stateReg == FRWG_DONE)
		else $error("Final pass did not finish playback.");

	irq_clear_a: assert property (
		wr && paddr == IRQ_SOURCE_OFFS && pwdata == 32'h0000_0000
		|=> srcReg == 2'h0 && !masterReg)
		else $error("Zero source write did not clear events.");

	halt_stop_a: assert property (
		wr && paddr == START_STOP_OFFS && pwdata == HALT_CODE
		|=> stateReg == FRWG_IDLE)
		else $error("Halt code did not stop playback.");

	state_onehot_a: assert property ($onehot(stateReg))
		else $error("Playback state is not one-hot.");

	idle_still_a: assert property (
		stateReg == FRWG_IDLE && !wr |=> $stable(rdPtrReg))
		else $error("Read pointer moved while idle.");
endmodule

// file: frwg_port_monitor.sv
// Far-side model: a clock-line consumer that counts words seen on the port.
`timescale 1ns/1ps
module frwg_port_monitor (
	input wire logic core_clk,
	input wire logic rst_n,
	input frwg_pkg::frwg_word_t portWord,
	output logic [15:0] wordCount
);
	import frwg_pkg::*;
	frwg_word_t lastWord;
	// Each change of either half counts as one word; a held word is silent.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			lastWord <= '0;
			wordCount <= 16'h0;
		end else if (portWord !== lastWord) begin
			lastWord <= portWord;
			wordCount <= wordCount + 16'h1;
		end
	end
endmodule

// file: fifo_repeat_waveform_generator_test.sv
// Testbench for the waveform generator with a port monitor at the far side.
`timescale 1ns/1ps
module fifo_repeat_waveform_generator_test;
	import frwg_pkg::*;
	logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr, eventLine;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic err;
	frwg_word_t portWord;
	logic [15:0] wordCount, c0;
	int fails = 0;
	int num_checks = 0;
	frwg_generator #(.DEPTH(16)) dut (.core_clk(core_clk), .rst_n(rst_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .portWord(portWord), .eventLine(eventLine));
	frwg_port_monitor far (.core_clk(core_clk), .rst_n(rst_n),
		.portWord(portWord), .wordCount(wordCount));
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	task report_and_stop();
		$display("Checks %0d, errors %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task timeout(input string nm);
		fails++;
		$display("Error %s expected answer seen timeout", nm);
		report_and_stop();
	endtask
	// The request stands until pready is sampled high at a rising edge.
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			timeout("pready");
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, rd, err);
	endtask
	task wait_port(input logic [31:0] w);
		int n;
		n = 0;
		while (portWord !== w && n < 200) begin
			@(posedge core_clk);
			n++;
		end
		if (n >= 200) begin
			timeout("portWord");
		end
		chk("portWord", w, portWord);
	endtask
	task wait_event();
		int n;
		logic s;
		n = 0;
		s = eventLine;
		while (eventLine === s && n < 400) begin
			@(posedge core_clk);
			n++;
		end
		if (n >= 400) begin
			timeout("eventLine");
		end
	endtask
	task arm(input logic [31:0] src);
		wr(IRQ_SOURCE_OFFS, 32'h0);
		wr(IRQ_SOURCE_OFFS, src);
		wr(IRQ_MASTER_OFFS, MASTER_ENABLE_CODE);
	endtask
	task load(input int n, input logic [31:0] base);
		wr(QUEUE_CLEAR_OFFS, 32'h5a);
		for (int i = 0; i < n; i++) begin
			wr(QUEUE_WINDOW_OFFS, base << i);
		end
	endtask
	task direct_path_test();
		wr(PATH_SELECT_OFFS, DIRECT_PATH_CODE);
		wr(DIRECT_WORD_OFFS, 32'hffffffff);
		wait_port(32'hffffffff);
		wr(DIRECT_WORD_OFFS, 32'h0);
		wait_port(32'h0);
		apb(1'b0, 8'h3c, 32'h0, rd, err);
		chk("pslverr", 32'h1, {31'h0, err});
	endtask
	task queue_replay_test();
		load(4, 32'h1);
		wr(QUEUE_CONTROL_OFFS, COMBINED_CODE);
		wr(REPEAT_COUNT_OFFS, 32'h2000);
		apb(1'b0, REPEAT_COUNT_OFFS, 32'h0, rd, err);
		chk("repeatCount", 32'h1000_1000, rd);
		wr(REPEAT_COUNT_OFFS, 32'h2);
		apb(1'b0, REPEAT_COUNT_OFFS, 32'h0, rd, err);
		chk("repeatCount", 32'h0002_0002, rd);
		wr(PATH_SELECT_OFFS, QUEUE_PATH_CODE);
		arm(REPLAY_IRQ_CODE);
		c0 = wordCount;
		wr(START_STOP_OFFS, RUN_CODE);
		for (int i = 0; i < 4; i++) begin
			wait_port(32'h1 << i);
		end
		wait_event();
		arm(PLAYBACK_DONE_IRQ_CODE);
		for (int i = 0; i < 4; i++) begin
			wait_port(32'h1 << i);
		end
		wait_event();
		wr(START_STOP_OFFS, HALT_CODE);
		chk("wordCount", 32'h8, {16'h0, wordCount - c0});
		// A direct word is refused while the queue owns the port.
		wr(DIRECT_WORD_OFFS, 32'h1234);
		repeat (4) @(posedge core_clk);
		chk("heldWord", 32'h8, portWord);
	endtask
	task clear_test();
		// Stale words left in the queue would come out first.
		load(2, 32'h10000);
		wr(REPEAT_COUNT_OFFS, 32'h1);
		arm(PLAYBACK_DONE_IRQ_CODE);
		wr(START_STOP_OFFS, RUN_CODE);
		wait_port(32'h10000);
		wait_port(32'h20000);
		wait_event();
		wr(START_STOP_OFFS, HALT_CODE);
	endtask
	task split_halves_test();
		// Separate halves: only the low half follows the queue.
		wr(QUEUE_CONTROL_OFFS, 32'h0);
		load(1, 32'h0003_0005);
		wr(REPEAT_COUNT_OFFS, 32'h1);
		wr(START_STOP_OFFS, RUN_CODE);
		wait_port(32'h0002_0005);
		wait_event();
		wr(START_STOP_OFFS, HALT_CODE);
	endtask
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h0;
		pwdata = 32'h0;
		rst_n = 1'b0;
		repeat (4) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		direct_path_test();
		queue_replay_test();
		clear_test();
		split_halves_test();
		report_and_stop();
	end
endmodule
